// [strobe_processor_model.sv]
// Purpose: processor on the far side: takes reset_out_n, drives the watchdog strobe
// Assumes: pins tri-state while reset is held, as on a real processor
// Notes: mode 0 holds strobe low, 1 services it every gap+1 cycles, 2 leaves it floating
`timescale 1ns/100ps

module strobe_processor_model (
    input wire logic mclk,
    input wire logic reset_out_n,
    input wire logic [1:0] mode,
    input wire logic [7:0] gap,
    output logic strobe_drv,
    output logic strobe_en
);
    logic [7:0] tick_reg; // cycles since the last service pulse

    // strong drive only out of reset and when not floating
    always_ff @(posedge mclk) begin
        strobe_en <= reset_out_n && (mode != 2'h2);
        if (!reset_out_n || mode != 2'h1) begin
            tick_reg <= 8'h00;
            strobe_drv <= 1'b0;
        end else begin
            tick_reg <= (tick_reg >= gap) ? 8'h00 : tick_reg + 8'h01;
            // idle low, short high pulse long enough to pass the input filter
            strobe_drv <= (tick_reg < 8'h03);
        end
    end
endmodule

// [supply_supervisor_pkg.sv]
// Purpose: constants for the supply supervisor and watchdog block
// Assumes: 25 MHz free-running clock on mclk
// Notes: long counts are top-level parameters fed from these defaults
// Behaviour
// - power-up holds reset at least 140 ms
// - supply below trip asserts both reset outputs
// - pushbutton low asserts reset; input idles high
// - accepted press gives reset pulse of 140+ ms
// - hold period starts when pushbutton released
// - no strobe edge within 1.12 s resets
// - watchdog counts only while reset inactive
// - strobe edge clears watchdog counter, restarts
// - expiry holds reset, releases, resumes watchdog
// - floating strobe pulled low 7/8, high 1/8
// - hold period 140 to 400 ms, 200 chosen
// - pushbutton glitches of 100 ns ignored
package supply_supervisor_pkg;

    // clock rate
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned CLK_NS = 40;

    // reset hold period, chosen inside the 140..400 ms window
    localparam int unsigned HOLD_MIN_MS = 140;
    localparam int unsigned HOLD_MAX_MS = 400;
    localparam int unsigned HOLD_MS = 200;
    localparam int unsigned HOLD_CYC = HOLD_MS * (CLK_HZ / 1000);

    // watchdog period, least figure
    localparam int unsigned WD_MS = 1120;
    localparam int unsigned WD_CYC = WD_MS * (CLK_HZ / 1000);

    // self-drive pattern: low for 7/8, high for 1/8 of a period
    localparam int unsigned PAT_LOW_NUM = 7;
    localparam int unsigned PAT_DEN = 8;

    // pushbutton noise immunity, rounded up to whole cycles
    localparam int unsigned NOISE_NS = 100;
    localparam int unsigned NOISE_CYC = (NOISE_NS + CLK_NS - 1) / CLK_NS;

    // counter widths
    localparam int unsigned CNT_W = 25;
    localparam int unsigned NOISE_W = 3;

    // input synchroniser bit positions
    localparam int unsigned SYNC_W = 3;
    localparam int unsigned SYN_SUPPLY = 0;
    localparam int unsigned SYN_BUTTON = 1;
    localparam int unsigned SYN_STROBE = 2;

    // reset values of the filtered inputs: supply low, button idle, strobe low
    localparam logic [2:0] SYNC_RST = 3'h3;

    // supervisor states
    typedef enum logic [1:0] {
        ST_CAUSE,
        ST_HOLD,
        ST_RUN
    } sup_state_t;

endpackage

// [supply_supervisor_watchdog.sv]
// Purpose: reset supervisor with pushbutton input and watchdog timer
// Assumes: supply_low comes from an analog comparator, asynchronous
// Notes: strobe pin is two-way; drive is weak and any external driver wins
`timescale 1ns/100ps

module supply_supervisor_watchdog #(
    parameter int unsigned HOLD_CYCLES = supply_supervisor_pkg::HOLD_CYC,
    parameter int unsigned WD_CYCLES = supply_supervisor_pkg::WD_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic supply_low,
    input wire logic pushbutton_reset_n,
    input wire logic watchdog_strobe_in,
    output logic watchdog_strobe_out,
    output logic watchdog_strobe_oe,
    output logic reset_out_n,
    output logic reset_out
);
    import supply_supervisor_pkg::*;

    // derived counts at counter width
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_CYCLES - 1);
    localparam logic [CNT_W-1:0] PAT_HIGH = CNT_W'((WD_CYCLES / PAT_DEN) * PAT_LOW_NUM);
    localparam logic [NOISE_W-1:0] NOISE_LIM = NOISE_W'(NOISE_CYC);

    // three-stage synchronisers and filtered levels
    logic [SYNC_W-1:0] sync1_reg; // first stage, read by stage two only
    logic [SYNC_W-1:0] sync2_reg; // second stage
    logic [SYNC_W-1:0] sync3_reg; // third stage
    logic [SYNC_W-1:0] filt_reg; // level accepted when stages agree

    // state and counters
    sup_state_t state_reg; // supervisor state
    sup_state_t state_next; // next supervisor state
    logic [CNT_W-1:0] hold_reg; // reset hold counter
    logic [CNT_W-1:0] wd_reg; // watchdog counter
    logic [CNT_W-1:0] pat_reg; // self-drive pattern counter
    logic [NOISE_W-1:0] low_reg; // pushbutton low run length
    logic press_reg; // accepted pushbutton press
    logic strobe_prev_reg; // last filtered strobe level

    // decoded conditions
    logic supply_bad; // supply under trip level
    logic button_low; // filtered pushbutton level is low
    logic strobe_edge; // strobe changed level
    logic wd_expire; // watchdog ran out this cycle
    logic cause; // any reason to hold reset

    // sample the asynchronous inputs into mclk
    always_ff @(posedge mclk) begin
        if (rst) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
            sync3_reg <= SYNC_RST;
        end else begin
            sync1_reg <= {watchdog_strobe_in, pushbutton_reset_n, supply_low};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // accept a level once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_filt
            always_ff @(posedge mclk) begin
                if (rst) begin
                    filt_reg[gi] <= SYNC_RST[gi];
                end else if (sync2_reg[gi] == sync3_reg[gi]) begin
                    filt_reg[gi] <= sync3_reg[gi];
                end
            end
        end
    endgenerate

    // decoded conditions
    assign supply_bad = filt_reg[SYN_SUPPLY];
    assign button_low = !filt_reg[SYN_BUTTON];
    assign strobe_edge = filt_reg[SYN_STROBE] != strobe_prev_reg;
    assign wd_expire = (state_reg == ST_RUN) && (wd_reg == WD_LAST) && !strobe_edge;
    assign cause = supply_bad || press_reg || wd_expire;

    // pushbutton: short low glitches never become a press
    always_ff @(posedge mclk) begin
        if (rst) begin
            low_reg <= '0;
            press_reg <= 1'b0;
        end else if (!button_low) begin
            // released: press ends here, hold starts after
            low_reg <= '0;
            press_reg <= 1'b0;
        end else if (low_reg < NOISE_LIM) begin
            // still within the noise window
            low_reg <= low_reg + NOISE_W'(1);
        end else begin
            // low long enough to be a real press
            press_reg <= 1'b1;
        end
    end

    // next state of the supervisor
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_CAUSE: begin
                // wait for every cause to clear
                if (!cause) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // count the hold period; a new cause restarts it
                if (cause) begin
                    state_next = ST_CAUSE;
                end else if (hold_reg == HOLD_LAST) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                // supply drop, press or expiry asserts reset
                if (cause) begin
                    state_next = ST_CAUSE;
                end
            end
        endcase
    end

    // supervisor state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= ST_CAUSE;
        end else begin
            state_reg <= state_next;
        end
    end

    // hold counter runs only in the hold state
    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_reg <= '0;
        end else if (state_reg == ST_HOLD && !cause) begin
            hold_reg <= hold_reg + CNT_W'(1);
        end else begin
            hold_reg <= '0;
        end
    end

    // watchdog counter: cleared during reset and on every strobe edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            wd_reg <= '0;
            strobe_prev_reg <= 1'b0;
        end else begin
            strobe_prev_reg <= filt_reg[SYN_STROBE];
            if (state_reg != ST_RUN || cause) begin
                // no timing while reset is held
                wd_reg <= '0;
            end else if (strobe_edge) begin
                // serviced: start again from zero
                wd_reg <= '0;
            end else begin
                wd_reg <= wd_reg + CNT_W'(1);
            end
        end
    end

    // free-running pattern for the weak strobe drive
    always_ff @(posedge mclk) begin
        if (rst) begin
            pat_reg <= '0;
            watchdog_strobe_out <= 1'b0;
            watchdog_strobe_oe <= 1'b0;
        end else begin
            if (pat_reg == WD_LAST) begin
                pat_reg <= '0;
            end else begin
                pat_reg <= pat_reg + CNT_W'(1);
            end
            // low for the first part, high for the last eighth
            watchdog_strobe_out <= (pat_reg >= PAT_HIGH);
            watchdog_strobe_oe <= 1'b1;
        end
    end

    // both reset outputs come from the one next state
    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_out_n <= 1'b0;
            reset_out <= 1'b1;
        end else begin
            reset_out_n <= (state_next == ST_RUN);
            reset_out <= (state_next != ST_RUN);
        end
    end

    // outputs are always complementary
    property p_compl;
        @(posedge mclk) disable iff (rst)
        reset_out == !reset_out_n;
    endproperty
    a_compl: assert property (p_compl) else $error("reset outputs not complementary");

    // low supply asserts reset next cycle
    property p_supply;
        @(posedge mclk) disable iff (rst)
        supply_bad |=> !reset_out_n && reset_out;
    endproperty
    a_supply: assert property (p_supply) else $error("supply low did not assert reset");

    // an accepted press asserts reset next cycle
    property p_press;
        @(posedge mclk) disable iff (rst)
        press_reg |=> !reset_out_n;
    endproperty
    a_press: assert property (p_press) else $error("press did not assert reset");

    // a press only after the noise window
    property p_noise;
        @(posedge mclk) disable iff (rst)
        $rose(press_reg) |-> $past(low_reg) == NOISE_LIM;
    endproperty
    a_noise: assert property (p_noise) else $error("press accepted inside noise window");

    // release only after a full hold count
    property p_hold_len;
        @(posedge mclk) disable iff (rst)
        $rose(reset_out_n) |-> $past(hold_reg) == HOLD_LAST && $past(state_reg) == ST_HOLD;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset released early");

    // release never while a cause stands
    property p_release;
        @(posedge mclk) disable iff (rst)
        $rose(reset_out_n) |-> !$past(supply_bad) && !$past(press_reg) && !$past(button_low);
    endproperty
    a_release: assert property (p_release) else $error("reset released with cause");

    // watchdog idle while reset is held
    property p_wd_idle;
        @(posedge mclk) disable iff (rst)
        state_reg != ST_RUN |-> wd_reg == '0;
    endproperty
    a_wd_idle: assert property (p_wd_idle) else $error("watchdog counted during reset");

    // a strobe edge clears the watchdog
    property p_service;
        @(posedge mclk) disable iff (rst)
        strobe_edge |=> wd_reg == '0;
    endproperty
    a_service: assert property (p_service) else $error("strobe edge did not clear watchdog");

    // expiry asserts reset and then holds
    property p_expire;
        @(posedge mclk) disable iff (rst)
        wd_expire |=> !reset_out_n ##1 (state_reg != ST_RUN);
    endproperty
    a_expire: assert property (p_expire) else $error("expiry did not assert reset");

    // weak drive follows the pattern
    property p_pattern;
        @(posedge mclk) disable iff (rst)
        pat_reg < PAT_HIGH |=> !watchdog_strobe_out && watchdog_strobe_oe;
    endproperty
    a_pattern: assert property (p_pattern) else $error("strobe drive not low in first part");

    // weak drive goes high for the last eighth
    property p_pattern_high;
        @(posedge mclk) disable iff (rst)
        pat_reg >= PAT_HIGH |=> watchdog_strobe_out && watchdog_strobe_oe;
    endproperty
    a_pattern_high: assert property (p_pattern_high) else $error("strobe drive not high in last part");

    // an accepted press stays while the button is still low
    property p_press_hold;
        @(posedge mclk) disable iff (rst)
        press_reg && button_low |=> press_reg;
    endproperty
    a_press_hold: assert property (p_press_hold) else $error("press dropped while button low");

    // a low level inside the noise window never becomes a press
    property p_noise_quiet;
        @(posedge mclk) disable iff (rst)
        button_low && low_reg < NOISE_LIM |=> !press_reg;
    endproperty
    a_noise_quiet: assert property (p_noise_quiet) else $error("press taken inside noise window");

    // a new cause during the hold restarts it from zero
    property p_hold_restart;
        @(posedge mclk) disable iff (rst)
        state_reg == ST_HOLD && cause |=> state_reg == ST_CAUSE && hold_reg == '0;
    endproperty
    a_hold_restart: assert property (p_hold_restart) else $error("hold not restarted by new cause");

    // after release the watchdog starts again from zero
    property p_resume;
        @(posedge mclk) disable iff (rst)
        $rose(reset_out_n) |-> wd_reg == '0;
    endproperty
    a_resume: assert property (p_resume) else $error("watchdog not restarted at release");

    // main scenarios
    c_press: cover property (@(posedge mclk) disable iff (rst) $rose(press_reg));
    c_expire: cover property (@(posedge mclk) disable iff (rst) wd_expire);
    c_release: cover property (@(posedge mclk) disable iff (rst) $rose(reset_out_n));
    c_brown: cover property (@(posedge mclk) disable iff (rst) state_reg == ST_RUN && supply_bad);

endmodule

// [tb_supply_supervisor_watchdog.sv]
// Purpose: self-checking bench for the supply supervisor with watchdog
// Assumes: short hold and watchdog counts so the run stays brief
// Notes: strobe pin resolved here; processor drive strong, device drive weak
`timescale 1ns/100ps

module tb_supply_supervisor_watchdog;
    import supply_supervisor_pkg::*;
    localparam int HOLD = 20; // shortened hold period
    localparam int WD = 64; // shortened watchdog period
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic supply_low = 1'b1; // supply starts below trip level
    logic pushbutton_reset_n = 1'b1; // pull-up idle level
    logic [1:0] mode = 2'h1;
    logic [7:0] gap = 8'h28;
    logic hold_lvl = 1'b0; // floating pin settles to the inverse of its last level
    logic strobe_drv, strobe_en, strobe_out, strobe_oe, reset_out_n, reset_out;
    wire strobe_pin;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    assign strobe_pin = (strobe_en === 1'b1) ? strobe_drv : ((strobe_oe === 1'b1) ? strobe_out : hold_lvl);

    supply_supervisor_watchdog #(.HOLD_CYCLES(HOLD), .WD_CYCLES(WD)) dut_u (
        .mclk(mclk), .rst(rst), .supply_low(supply_low), .pushbutton_reset_n(pushbutton_reset_n),
        .watchdog_strobe_in(strobe_pin), .watchdog_strobe_out(strobe_out),
        .watchdog_strobe_oe(strobe_oe), .reset_out_n(reset_out_n), .reset_out(reset_out));

    strobe_processor_model proc_u (.mclk(mclk), .reset_out_n(reset_out_n), .mode(mode), .gap(gap),
        .strobe_drv(strobe_drv), .strobe_en(strobe_en));

    // clock generator
    initial begin
        forever #20 mclk = ~mclk;
    end

    // floating level and cycle ceiling
    always @(posedge mclk) begin
        hold_lvl <= ~strobe_pin;
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            conclude();
        end
    end

    // both outputs come from one state
    always @(negedge mclk) begin
        if (!rst) chk(reset_out === ~reset_out_n, "outputs not complementary");
    end

    task automatic chk(input bit ok, input string msg);
        check_count++;
        if (!ok) begin
            bad_count++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    // cycles until reset_out_n shows lvl, at most lim
    task automatic wait_rst(input logic lvl, input int lim, output int k);
        k = 0;
        while (reset_out_n !== lvl && k < lim) begin
            step(1);
            k++;
        end
    endtask

    task automatic power_up();
        step(20);
        rst = 1'b0;
        step(10);
        chk(reset_out_n === 1'b0, "reset released while supply low");
        supply_low = 1'b0;
        wait_rst(1'b1, HOLD + 20, n);
        chk(n >= HOLD && n <= HOLD + 8, "power-up hold length");
    endtask

    task automatic brownout();
        supply_low = 1'b1;
        wait_rst(1'b0, 10, n);
        chk(n < 10, "no reset on brownout");
        step(2);
        supply_low = 1'b0;
        wait_rst(1'b1, HOLD + 20, n);
        chk(n >= HOLD && n <= HOLD + 8, "brownout hold length");
    endtask

    task automatic button();
        pushbutton_reset_n = 1'b0;
        wait_rst(1'b0, 15, n);
        chk(n < 15, "no reset on press");
        step(40);
        chk(reset_out_n === 1'b0, "reset dropped while pressed");
        pushbutton_reset_n = 1'b1;
        wait_rst(1'b1, HOLD + 20, n);
        chk(n >= HOLD && n <= HOLD + 10, "hold not timed from release");
    endtask

    task automatic glitch();
        pushbutton_reset_n = 1'b0;
        step(2);
        pushbutton_reset_n = 1'b1;
        wait_rst(1'b0, 30, n);
        chk(n == 30, "short press caused reset");
    endtask

    task automatic serviced();
        gap = 8'h32;
        wait_rst(1'b0, 5 * WD, n);
        chk(n == 5 * WD, "reset despite strobe edges");
    endtask

    task automatic floating();
        mode = 2'h2;
        step(4);
        n = 0;
        repeat (WD) begin
            if (strobe_oe === 1'b1 && strobe_out === 1'b1) n++;
            step(1);
        end
        chk(n == WD / 8, "self-drive high share");
        wait_rst(1'b0, 5 * WD, n);
        chk(n == 5 * WD, "reset while strobe floats");
    endtask

    task automatic expiry();
        mode = 2'h0;
        wait_rst(1'b0, WD + 20, n);
        chk(n <= WD + 10, "no expiry without strobe");
        wait_rst(1'b1, HOLD + 20, n);
        chk(n >= HOLD && n <= HOLD + 8, "expiry hold length");
        wait_rst(1'b0, WD + 20, n);
        chk(n >= WD - 1 && n <= WD + 8, "timeout not counted from release");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        power_up();
        brownout();
        button();
        glitch();
        serviced();
        floating();
        expiry();
        conclude();
    end
endmodule
